/* File: design/dcr_regs.svh */
// Offsets, fixed capability values and field positions for the
// capability register bank.
// Assumes a byte-addressed register port with aligned 32-bit words.
// Summary of operation
// (R01) Every capability register returns its fixed value on each read.
// (R02) A capability bit of zero means that module or pin is absent.
// (R03) A gating enable whose capability bit is zero cannot be set.
// (R04) The port register returns ones in bits 0 to 8, ports A to J.
// (R05) The pwm register returns ones in bits 0 to 7, pulse outputs 0 to 7.
// (R06) A dma presence bit of one means the channel exists on this part.
// (R07) A channel whose primary peer is absent uses its secondary peer.
// (R08) A channel without a secondary peer stays on its primary peer; channel 31, which lacks both peers, has dma_use_secondary set.
// (R09) Software ignores reserved bits and writes back what it read.
// (R10) An assignment bit of one moves the channel to its secondary peer.
// (R11) Writes to capability registers are ignored and change no read.
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

`define DCR_ADDR_W          12
`define DCR_DATA_W          32

`define DCR_OFF_PORT        12'h01c
`define DCR_OFF_PWM         12'h020
`define DCR_OFF_USB         12'h024
`define DCR_OFF_DMA         12'h028
`define DCR_OFF_RUN_GATE    12'h100
`define DCR_OFF_SLEEP_GATE  12'h104
`define DCR_OFF_DEEP_GATE   12'h108
`define DCR_OFF_DMA_ASSIGN  12'h10c

`define DCR_VAL_PORT        32'h5004_f1ff
`define DCR_VAL_PWM         32'h0f30_00ff
`define DCR_VAL_USB         32'h0000_0013
`define DCR_VAL_DMA         32'hffff_ffff

`define DCR_DMA_PRIM_PRESENT 32'h7fff_ffff
`define DCR_DMA_SEC_PRESENT  32'h3ffc_ffff

`define DCR_IO_PORT_LSB     0
`define DCR_IO_PORT_MSB     8
`define DCR_IO_PORT_ALL     9'h1ff
`define DCR_PULSE_OUT_LSB   0
`define DCR_PULSE_OUT_MSB   7
`define DCR_PULSE_OUT_ALL   8'hff

`define DCR_GATE_RST        32'h0000_0000
`define DCR_ASSIGN_RST      32'h0000_0000
`define DCR_RDATA_IDLE      32'h0000_0000

`endif

/* File: design/dcr_pkg.sv */
// Types shared by the capability register bank.
// Assumes dcr_regs.svh supplies the widths.
`include "dcr_regs.svh"

package dcr_pkg;

  typedef logic [`DCR_DATA_W-1:0] dcr_word_t;
  typedef logic [`DCR_ADDR_W-1:0] dcr_addr_t;

  // One-hot register select
  typedef enum logic [8:0] {
    DCR_SEL_NONE   = 9'h001,
    DCR_SEL_PORT   = 9'h002,
    DCR_SEL_PWM    = 9'h004,
    DCR_SEL_USB    = 9'h008,
    DCR_SEL_DMA    = 9'h010,
    DCR_SEL_RUN    = 9'h020,
    DCR_SEL_SLEEP  = 9'h040,
    DCR_SEL_DEEP   = 9'h080,
    DCR_SEL_ASSIGN = 9'h100
  } dcr_sel_e;

endpackage : dcr_pkg

/* File: design/dcr_link_if.sv */
// Internal carrier between the bank top and its two helpers.
// Assumes all parties run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface dcr_link_if;
  dcr_pkg::dcr_word_t gate_wdata;
  dcr_pkg::dcr_word_t gate_mask;
  dcr_pkg::dcr_word_t gate_masked;
  dcr_pkg::dcr_word_t ch_present;
  dcr_pkg::dcr_word_t prim_present;
  dcr_pkg::dcr_word_t sec_present;
  dcr_pkg::dcr_word_t assign_bits;
  dcr_pkg::dcr_word_t use_secondary;

  modport top_mp (
    output gate_wdata, gate_mask, ch_present, prim_present, sec_present,
    output assign_bits,
    input  gate_masked, use_secondary
  );
  modport gate_mp (
    input  gate_wdata, gate_mask,
    output gate_masked
  );
  modport route_mp (
    input  ch_present, prim_present, sec_present, assign_bits,
    output use_secondary
  );
endinterface : dcr_link_if

`default_nettype wire

/* File: design/dcr_gate_filter.sv */
// Clears every gating write bit whose module is absent.
// Assumes the mask is the fixed capability word.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_regs.svh"

module dcr_gate_filter (
  dcr_link_if.gate_mp link
);

  genvar i;
  generate
    for (i = 0; i < `DCR_DATA_W; i++) begin : g_bit
      // (R03) absent module gate
      assign link.gate_masked[i] = link.gate_wdata[i] & link.gate_mask[i];
    end
  endgenerate

endmodule : dcr_gate_filter

`default_nettype wire

/* File: design/dcr_dma_route.sv */
// Per-channel choice between primary and secondary peer.
// Assumes presence vectors are fixed and assignment bits registered.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_regs.svh"

module dcr_dma_route (
  dcr_link_if.route_mp link
);

  genvar i;
  generate
    for (i = 0; i < `DCR_DATA_W; i++) begin : g_ch
      logic prim_gone;
      logic sec_pick;
      // (R07) absent primary fallback
      assign prim_gone = ~link.prim_present[i];
      // (R08) (R10) secondary only if present
      assign sec_pick  = link.sec_present[i] & link.assign_bits[i];
      assign link.use_secondary[i] = link.ch_present[i] &
                                     (prim_gone | sec_pick);
    end
  endgenerate

endmodule : dcr_dma_route

`default_nettype wire

/* File: design/dcr_top.sv */
// Capability register bank with gating enables and dma routing.
// Assumes a single-cycle strobe master on clk; reads answer next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_regs.svh"

module dcr_top (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [`DCR_ADDR_W-1:0] addr,
  input  wire logic [`DCR_DATA_W-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [`DCR_DATA_W-1:0] rdata,
  output logic      [`DCR_DATA_W-1:0] run_clock_gating,
  output logic      [`DCR_DATA_W-1:0] sleep_clock_gating,
  output logic      [`DCR_DATA_W-1:0] deep_sleep_clock_gating,
  output logic      [`DCR_DATA_W-1:0] dma_channel_assignment,
  output logic      [`DCR_DATA_W-1:0] dma_use_secondary,
  output logic      [`DCR_DATA_W-1:0] dma_channel_enable
);

  // Values fixed by the part; no flops, so nothing can alter them
  // (R04) ports A to J
  localparam dcr_pkg::dcr_word_t PORT_CAP = `DCR_VAL_PORT;
  // (R05) pulse outputs 0 to 7
  localparam dcr_pkg::dcr_word_t PWM_CAP  = `DCR_VAL_PWM;
  localparam dcr_pkg::dcr_word_t USB_CAP  = `DCR_VAL_USB;
  // (R06) every channel present
  localparam dcr_pkg::dcr_word_t DMA_CAP  = `DCR_VAL_DMA;
  // (R07) (R08) peer presence per channel
  localparam dcr_pkg::dcr_word_t PRIM_OK  = `DCR_DMA_PRIM_PRESENT;
  localparam dcr_pkg::dcr_word_t SEC_OK   = `DCR_DMA_SEC_PRESENT;

  dcr_pkg::dcr_sel_e  sel;
  dcr_pkg::dcr_word_t next_rdata;
  logic               wr_run;
  logic               wr_sleep;
  logic               wr_deep;
  logic               wr_assign;

  dcr_link_if link ();

  // Exact decode; misaligned offsets fall to no select
  always_comb begin
    case (addr)
      `DCR_OFF_PORT:       sel = dcr_pkg::DCR_SEL_PORT;
      `DCR_OFF_PWM:        sel = dcr_pkg::DCR_SEL_PWM;
      `DCR_OFF_USB:        sel = dcr_pkg::DCR_SEL_USB;
      `DCR_OFF_DMA:        sel = dcr_pkg::DCR_SEL_DMA;
      `DCR_OFF_RUN_GATE:   sel = dcr_pkg::DCR_SEL_RUN;
      `DCR_OFF_SLEEP_GATE: sel = dcr_pkg::DCR_SEL_SLEEP;
      `DCR_OFF_DEEP_GATE:  sel = dcr_pkg::DCR_SEL_DEEP;
      `DCR_OFF_DMA_ASSIGN: sel = dcr_pkg::DCR_SEL_ASSIGN;
      default:             sel = dcr_pkg::DCR_SEL_NONE;
    endcase
  end

  // (R11) capability writes dropped
  assign wr_run    = wr && (sel == dcr_pkg::DCR_SEL_RUN);
  assign wr_sleep  = wr && (sel == dcr_pkg::DCR_SEL_SLEEP);
  assign wr_deep   = wr && (sel == dcr_pkg::DCR_SEL_DEEP);
  assign wr_assign = wr && (sel == dcr_pkg::DCR_SEL_ASSIGN);

  // Gating uses the port and network word as its presence mask
  assign link.gate_wdata   = wdata;
  assign link.gate_mask    = PORT_CAP;
  assign link.ch_present   = DMA_CAP;
  assign link.prim_present = PRIM_OK;
  assign link.sec_present  = SEC_OK;
  // (R10) assignment steers routing
  assign link.assign_bits  = dma_channel_assignment;

  dcr_gate_filter u_gate (
    .link (link.gate_mp)
  );

  dcr_dma_route u_route (
    .link (link.route_mp)
  );

  // (R03) masked gating stores
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_clock_gating <= `DCR_GATE_RST;
    end else if (wr_run) begin
      run_clock_gating <= link.gate_masked;
    end
  end

  // (R03) masked gating stores
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_clock_gating <= `DCR_GATE_RST;
    end else if (wr_sleep) begin
      sleep_clock_gating <= link.gate_masked;
    end
  end

  // (R03) masked gating stores
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deep_sleep_clock_gating <= `DCR_GATE_RST;
    end else if (wr_deep) begin
      deep_sleep_clock_gating <= link.gate_masked;
    end
  end

  // (R08) no secondary, bit held clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dma_channel_assignment <= `DCR_ASSIGN_RST;
    end else if (wr_assign) begin
      dma_channel_assignment <= wdata & SEC_OK & DMA_CAP;
    end
  end

  // Routing is a pure function of flops and constants
  assign dma_use_secondary = link.use_secondary;
  // (R06) present channels enabled
  assign dma_channel_enable = DMA_CAP;

  // (R01) (R02) fixed read values; gating and assignment registers read back their flops
  always_comb begin
    next_rdata = `DCR_RDATA_IDLE;
    case (sel)
      dcr_pkg::DCR_SEL_PORT:   next_rdata = PORT_CAP;
      dcr_pkg::DCR_SEL_PWM:    next_rdata = PWM_CAP;
      dcr_pkg::DCR_SEL_USB:    next_rdata = USB_CAP;
      dcr_pkg::DCR_SEL_DMA:    next_rdata = DMA_CAP;
      dcr_pkg::DCR_SEL_RUN:    next_rdata = run_clock_gating;
      dcr_pkg::DCR_SEL_SLEEP:  next_rdata = sleep_clock_gating;
      dcr_pkg::DCR_SEL_DEEP:   next_rdata = deep_sleep_clock_gating;
      dcr_pkg::DCR_SEL_ASSIGN: next_rdata = dma_channel_assignment;
      default:                 next_rdata = `DCR_RDATA_IDLE;
    endcase
  end

  // Read data valid for one cycle only; idle zero otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= `DCR_RDATA_IDLE;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= `DCR_RDATA_IDLE;
    end
  end

  // Checks

  port_read_fixed_a: assert property ( // (R01)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_PORT) |=> (rdata == `DCR_VAL_PORT))
    else $error("port presence read returned wrong value");

  dma_read_fixed_a: assert property ( // (R01)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_DMA) |=> (rdata == `DCR_VAL_DMA))
    else $error("dma presence read returned wrong value");

  usb_absent_zero_a: assert property ( // (R02)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_USB) |=>
      ((rdata & ~`DCR_VAL_USB) == 32'h0000_0000 &&
       rdata == `DCR_VAL_USB))
    else $error("usb presence shows an absent bit set");

  run_gate_mask_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_RUN_GATE) |=>
      (run_clock_gating == ($past(wdata) & `DCR_VAL_PORT)))
    else $error("run gating accepted a bit for an absent module");

  gate_never_absent_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    ((sleep_clock_gating | deep_sleep_clock_gating) &
      ~`DCR_VAL_PORT) == 32'h0000_0000)
    else $error("sleep or deep gating holds an absent module bit");

  io_ports_present_a: assert property ( // (R04)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_PORT) |=>
      (rdata[`DCR_IO_PORT_MSB:`DCR_IO_PORT_LSB] == `DCR_IO_PORT_ALL))
    else $error("io port presence bits not all one");

  pulse_outs_present_a: assert property ( // (R05)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_PWM) |=>
      (rdata[`DCR_PULSE_OUT_MSB:`DCR_PULSE_OUT_LSB] == `DCR_PULSE_OUT_ALL))
    else $error("pulse output presence bits not all one");

  dma_enable_match_a: assert property ( // (R06)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_DMA) |=>
      (rdata == dma_channel_enable) && ((dma_use_secondary &
       ~dma_channel_enable) == 32'h0000_0000))
    else $error("dma enable disagrees with presence word");

  prim_fallback_a: assert property ( // (R07)
    @(posedge clk) disable iff (!resetn)
    ((~`DCR_DMA_PRIM_PRESENT & `DCR_VAL_DMA & ~dma_use_secondary)
      == 32'h0000_0000))
    else $error("channel with absent primary not on secondary");

  no_sec_stays_a: assert property ( // (R08)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_DMA_ASSIGN) |=>
      ((dma_use_secondary & ~`DCR_DMA_SEC_PRESENT &
        `DCR_DMA_PRIM_PRESENT) == 32'h0000_0000) &&
      ((dma_channel_assignment & ~`DCR_DMA_SEC_PRESENT) == 32'h0000_0000))
    else $error("channel without secondary left its primary");

  assign_routes_a: assert property ( // (R10)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_DMA_ASSIGN) |=>
      ((dma_use_secondary & `DCR_DMA_PRIM_PRESENT & `DCR_DMA_SEC_PRESENT)
       == ($past(wdata) & `DCR_DMA_PRIM_PRESENT & `DCR_DMA_SEC_PRESENT
           & `DCR_VAL_DMA)))
    else $error("assignment write did not steer the channel");

  cap_write_ignored_a: assert property ( // (R11)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_PWM) ##[1:4] (rd && addr == `DCR_OFF_PWM) |=>
      (rdata == `DCR_VAL_PWM))
    else $error("write to pwm presence changed its read value");

  gate_hold_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == `DCR_OFF_RUN_GATE) |=> $stable(run_clock_gating))
    else $error("run gating changed without a write to it");

  // Read path checks
  pwm_read_fixed_a: assert property ( // (R01)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_PWM) |=> (rdata == `DCR_VAL_PWM))
    else $error("pwm presence read returned wrong value");

  usb_read_fixed_a: assert property ( // (R01)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_USB) |=> (rdata == `DCR_VAL_USB))
    else $error("usb presence read returned wrong value");

  rdata_idle_a: assert property ( // (R01)
    @(posedge clk) disable iff (!resetn)
    !rd |=> (rdata == `DCR_RDATA_IDLE))
    else $error("read data not idle after a cycle without read");

  unmapped_read_zero_a: assert property ( // (R01)
    @(posedge clk) disable iff (!resetn)
    (rd && sel == dcr_pkg::DCR_SEL_NONE) |=> (rdata == `DCR_RDATA_IDLE))
    else $error("unmapped read returned nonzero data");

  port_reserved_zero_a: assert property ( // (R02)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_PORT) |=> (rdata[11:9] == 3'h0))
    else $error("port presence shows a reserved bit set");

  pwm_reserved_zero_a: assert property ( // (R02)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_PWM) |=> (rdata[19:8] == 12'h000))
    else $error("pwm presence shows a reserved bit set");

  // Gating state checks
  sleep_gate_mask_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_SLEEP_GATE) |=>
      (sleep_clock_gating == ($past(wdata) & `DCR_VAL_PORT)))
    else $error("sleep gating accepted a bit for an absent module");

  deep_gate_mask_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_DEEP_GATE) |=>
      (deep_sleep_clock_gating == ($past(wdata) & `DCR_VAL_PORT)))
    else $error("deep gating accepted a bit for an absent module");

  run_never_absent_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    ((run_clock_gating & ~`DCR_VAL_PORT) == 32'h0000_0000))
    else $error("run gating holds an absent module bit");

  sleep_hold_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == `DCR_OFF_SLEEP_GATE) |=> $stable(sleep_clock_gating))
    else $error("sleep gating changed without a write to it");

  deep_hold_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == `DCR_OFF_DEEP_GATE) |=>
      $stable(deep_sleep_clock_gating))
    else $error("deep gating changed without a write to it");

  run_read_back_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_RUN_GATE) |=>
      (rdata == $past(run_clock_gating)))
    else $error("run gating read back wrong value");

  sleep_read_back_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_SLEEP_GATE) |=>
      (rdata == $past(sleep_clock_gating)))
    else $error("sleep gating read back wrong value");

  deep_read_back_a: assert property ( // (R03)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_DEEP_GATE) |=>
      (rdata == $past(deep_sleep_clock_gating)))
    else $error("deep gating read back wrong value");

  // Routing state checks
  assign_read_back_a: assert property ( // (R10)
    @(posedge clk) disable iff (!resetn)
    (rd && addr == `DCR_OFF_DMA_ASSIGN) |=>
      (rdata == $past(dma_channel_assignment)))
    else $error("assignment read back wrong value");

  assign_hold_a: assert property ( // (R10)
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == `DCR_OFF_DMA_ASSIGN) |=>
      $stable(dma_channel_assignment))
    else $error("assignment changed without a write to it");

  route_formula_a: assert property ( // (R10)
    @(posedge clk) disable iff (!resetn)
    (dma_use_secondary == (`DCR_VAL_DMA & (~`DCR_DMA_PRIM_PRESENT |
      (`DCR_DMA_SEC_PRESENT & dma_channel_assignment)))))
    else $error("secondary routing disagrees with assignment");

  no_sec_clear_a: assert property ( // (R08)
    @(posedge clk) disable iff (!resetn)
    ((dma_channel_assignment & ~`DCR_DMA_SEC_PRESENT) == 32'h0000_0000))
    else $error("assignment holds a bit for a channel without secondary");

  chan_enable_const_a: assert property ( // (R06)
    @(posedge clk) disable iff (!resetn)
    (dma_channel_enable == `DCR_VAL_DMA))
    else $error("channel enable differs from presence word");

  // Capability writes must leave later reads untouched
  port_write_ignored_a: assert property ( // (R11)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_PORT) ##[1:4] (rd && addr == `DCR_OFF_PORT) |=>
      (rdata == `DCR_VAL_PORT))
    else $error("write to port presence changed its read value");

  dma_write_ignored_a: assert property ( // (R11)
    @(posedge clk) disable iff (!resetn)
    (wr && addr == `DCR_OFF_DMA) ##[1:4] (rd && addr == `DCR_OFF_DMA) |=>
      (rdata == `DCR_VAL_DMA))
    else $error("write to dma presence changed its read value");

endmodule : dcr_top

`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the capability register bank.
// Assumes dcr_top with single-cycle strobes and read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_regs.svh"

module tb;
  logic               clk;
  logic               resetn;
  logic               wr;
  logic               rd;
  dcr_pkg::dcr_addr_t addr;
  dcr_pkg::dcr_word_t wdata;
  dcr_pkg::dcr_word_t rdata;
  dcr_pkg::dcr_word_t run_g;
  dcr_pkg::dcr_word_t sleep_g;
  dcr_pkg::dcr_word_t deep_g;
  dcr_pkg::dcr_word_t assign_r;
  dcr_pkg::dcr_word_t use_sec;
  dcr_pkg::dcr_word_t ch_en;
  int                 n_fail;
  int                 check_count;
  int                 cycles = 0;

  dcr_top DUT (
    .clk                     (clk),
    .resetn                  (resetn),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr                      (wr),
    .rd                      (rd),
    .rdata                   (rdata),
    .run_clock_gating        (run_g),
    .sleep_clock_gating      (sleep_g),
    .deep_sleep_clock_gating (deep_g),
    .dma_channel_assignment  (assign_r),
    .dma_use_secondary       (use_sec),
    .dma_channel_enable      (ch_en)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(string name, dcr_pkg::dcr_word_t exp,
                       dcr_pkg::dcr_word_t got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Generous ceiling; the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic wr_reg(dcr_pkg::dcr_addr_t a, dcr_pkg::dcr_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(dcr_pkg::dcr_addr_t a, string name,
                        dcr_pkg::dcr_word_t exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(name, exp, rdata);
  endtask : rd_reg

  task automatic test_reset_values();
    check("run gate", 32'h0000_0000, run_g);
    check("assignment", 32'h0000_0000, assign_r);
    check("use secondary", 32'h8000_0000, use_sec);
    check("channel enable", `DCR_VAL_DMA, ch_en);
    check("idle rdata", 32'h0000_0000, rdata);
  endtask : test_reset_values

  task automatic test_fixed_reads();
    dcr_pkg::dcr_addr_t offs [4];
    dcr_pkg::dcr_word_t vals [4];
    offs = '{`DCR_OFF_PORT, `DCR_OFF_PWM, `DCR_OFF_USB, `DCR_OFF_DMA};
    vals = '{`DCR_VAL_PORT, `DCR_VAL_PWM, `DCR_VAL_USB, `DCR_VAL_DMA};
    rd_reg(`DCR_OFF_PORT, "port bits", `DCR_VAL_PORT);
    check("ports a to j", 32'h0000_01ff, rdata & 32'h0000_0fff);
    rd_reg(`DCR_OFF_PWM, "pwm bits", `DCR_VAL_PWM);
    check("pulse outputs", 32'h0000_00ff, rdata & 32'h0000_ffff);
    for (int i = 0; i < 4; i++) begin
      rd_reg(offs[i], "cap read", vals[i]);
      wr_reg(offs[i], ~vals[i]);
      wr_reg(offs[i], 32'hffff_ffff);
      rd_reg(offs[i], "cap after write", vals[i]);
    end
  endtask : test_fixed_reads

  task automatic test_unmapped();
    rd_reg(12'h030, "unmapped read", 32'h0000_0000);
    rd_reg(12'h01e, "misaligned read", 32'h0000_0000);
    rd_reg(`DCR_OFF_USB, "usb read", `DCR_VAL_USB);
    @(posedge clk);
    #1;
    check("rdata after one cycle", 32'h0000_0000, rdata);
  endtask : test_unmapped

  task automatic test_gating();
    dcr_pkg::dcr_addr_t offs [3];
    offs = '{`DCR_OFF_RUN_GATE, `DCR_OFF_DEEP_GATE, `DCR_OFF_SLEEP_GATE};
    for (int i = 0; i < 3; i++) begin
      wr_reg(offs[i], 32'hffff_ffff);
      rd_reg(offs[i], "gate readback", `DCR_VAL_PORT);
    end
    check("run gate", `DCR_VAL_PORT, run_g);
    check("sleep gate", `DCR_VAL_PORT, sleep_g);
    check("deep gate", `DCR_VAL_PORT, deep_g);
    // Clear sleep enables, writing reserved bits back as last read
    wr_reg(`DCR_OFF_SLEEP_GATE, rdata & 32'h0000_0e00);
    check("sleep cleared", 32'h0000_0000, sleep_g);
    check("run kept", `DCR_VAL_PORT, run_g);
    // Mid-run reset must clear the gating state
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    #1;
    check("run after reset", 32'h0000_0000, run_g);
    check("deep after reset", 32'h0000_0000, deep_g);
  endtask : test_gating

  task automatic test_dma_route();
    dcr_pkg::dcr_word_t exp;
    wr_reg(`DCR_OFF_DMA_ASSIGN, 32'hffff_ffff);
    check("assignment", `DCR_DMA_SEC_PRESENT, assign_r);
    exp = `DCR_VAL_DMA & (~`DCR_DMA_PRIM_PRESENT | `DCR_DMA_SEC_PRESENT);
    check("use secondary", exp, use_sec);
    rd_reg(`DCR_OFF_DMA_ASSIGN, "assign read", `DCR_DMA_SEC_PRESENT);
    wr_reg(`DCR_OFF_DMA_ASSIGN, 32'h0003_0000);
    check("no secondary kept", 32'h0000_0000, assign_r);
    check("primary only", 32'h8000_0000, use_sec);
    check("channel enable", `DCR_VAL_DMA, ch_en);
    wr_reg(`DCR_OFF_DMA_ASSIGN, 32'h0000_0001);
    check("one channel moved", 32'h8000_0001, use_sec);
  endtask : test_dma_route

  initial begin
    resetn      = 1'b0;
    wr          = 1'b0;
    rd          = 1'b0;
    addr        = '0;
    wdata       = '0;
    n_fail      = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1;
    test_reset_values();
    test_fixed_reads();
    test_unmapped();
    test_gating();
    test_dma_route();
    print_verdict();
  end
endmodule : tb

`default_nettype wire
